// ==== rtc_pkg.sv ====
// Purpose: Shared constants and types of the real-time counter block
// Assumes: Byte-wide register port, one peripheral clock
// Notes:   Offsets are byte addresses on the register port
package rtc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h01;
	localparam logic [7:0] OFS_FLAGS      = 8'h03;
	localparam logic [7:0] OFS_TEMP       = 8'h04;
	localparam logic [7:0] OFS_CORRECTION = 8'h06;
	localparam logic [7:0] OFS_SOURCE     = 8'h07;
	localparam logic [7:0] OFS_COUNT_LO   = 8'h08;
	localparam logic [7:0] OFS_COUNT_HI   = 8'h09;
	localparam logic [7:0] OFS_LIMIT_LO   = 8'h0a;
	localparam logic [7:0] OFS_LIMIT_HI   = 8'h0b;
	localparam logic [7:0] OFS_MATCH_LO   = 8'h0c;
	localparam logic [7:0] OFS_MATCH_HI   = 8'h0d;
	localparam logic [7:0] OFS_TICK_CTRL  = 8'h10;
	localparam logic [7:0] OFS_TICK_STATE = 8'h11;
	localparam logic [7:0] OFS_TICK_IRQEN = 8'h12;
	localparam logic [7:0] OFS_TICK_FLAG  = 8'h13;
	localparam logic [7:0] OFS_TICK_DEBUG = 8'h15;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE_BIT  = 0;
	localparam int CTL_CORR_BIT    = 2;
	localparam int CTL_PRESC_LSB   = 3;
	localparam int CORR_SIGN_BIT   = 7;
	localparam int TICK_ENABLE_BIT = 0;
	localparam int TICK_CODE_LSB   = 3;
	localparam int FLAG_WRAP_BIT   = 0;
	localparam int FLAG_MATCH_BIT  = 1;

	// Sync channels; CH_CTRL to CH_LIMIT are also the status bit positions, CH_TICK is bit 0 at OFS_TICK_STATE
	localparam int CH_CTRL  = 0;
	localparam int CH_COUNT = 1;
	localparam int CH_LIMIT = 2;
	localparam int CH_TICK  = 3;
	localparam int CH_NUM   = 4;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hffff;
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	localparam logic [3:0]  TICK_RESERVED = 4'hf;
	localparam logic [1:0]  SYNC_LAST   = 2'h1;   // two ticks: ages 0 and 1
	localparam logic [19:0] PPM_WINDOW  = 20'd1000000;
	localparam logic [4:0]  TAP_LAST    = 5'h1f;  // 32768 Hz / 32 = 1024 Hz
	localparam int          CLK_HZ      = 25000000;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_KHZ_TAP  = 2'h1,
		SRC_CRYSTAL  = 2'h2,
		SRC_EXTERNAL = 2'h3
	} source_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

endpackage : rtc_pkg

// ==== rtc_counter.sv ====
// Purpose: Real-time counter with crystal correction and tick timer
// Assumes: Timekeeping sources arrive as slow pins, sampled on clk
// Notes:   Timekeeping "cycles" are rising edges of the chosen source
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rtc_counter (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire rtc_pkg::bus_req_t bus,
	output logic [7:0]            rd_data,
	input  wire logic             osc_slow_pin,
	input  wire logic             crystal_pin,
	input  wire logic             ext_clock_pin,
	input  wire logic             debug_halt,
	output logic                  tick_irq
);

	function automatic logic [15:0] pow2_mask(input logic [4:0] n);
		pow2_mask = (16'h0001 << n) - 16'h0001;
	endfunction : pow2_mask

	// ----------------------------------------------------------------
	// Source pins: two-stage synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [2:0] pin_raw;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [2:0] pin_prev_q;
	logic [2:0] pin_rise;
	assign pin_raw = {ext_clock_pin, crystal_pin, osc_slow_pin};

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_pin
			always_ff @(posedge clk) begin
				if (srst) begin
					pin_meta_q[gp] <= 1'b0;
					pin_sync_q[gp] <= 1'b0;
					pin_prev_q[gp] <= 1'b0;
				end else begin
					pin_meta_q[gp] <= pin_raw[gp];
					pin_sync_q[gp] <= pin_meta_q[gp];
					pin_prev_q[gp] <= pin_sync_q[gp];
				end
			end
		end
	endgenerate
	assign pin_rise = pin_sync_q & ~pin_prev_q;

	// Kilohertz tap divides the internal oscillator by 32
	logic [4:0] tap_cnt_q;
	always_ff @(posedge clk) begin
		if (srst)
			tap_cnt_q <= 5'h00;
		else if (pin_rise[0])
			tap_cnt_q <= tap_cnt_q + 5'h01;
	end

	logic            [7:0] source_q;
	rtc_pkg::source_t      src_sel;
	logic                  rtc_tick;
	assign src_sel  = rtc_pkg::source_t'(source_q[1:0]);
	assign rtc_tick =
		(src_sel == rtc_pkg::SRC_INTERNAL) ? pin_rise[0] :
		(src_sel == rtc_pkg::SRC_KHZ_TAP)  ?
			(pin_rise[0] && tap_cnt_q == rtc_pkg::TAP_LAST) :
		(src_sel == rtc_pkg::SRC_CRYSTAL)  ? pin_rise[1] : pin_rise[2];

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	logic [7:0] a;
	logic [7:0] wd;
	logic       wr_ctrl, wr_flags, wr_temp, wr_corr, wr_src;
	logic       wr_cnt_lo, wr_cnt_hi, wr_lim_lo, wr_lim_hi;
	logic       wr_mat_lo, wr_mat_hi, wr_tick, wr_irqen, wr_tflag, wr_dbg;
	logic       rd_cnt_lo, rd_lim_lo, rd_mat_lo;
	assign a         = bus.addr;
	assign wd        = bus.wdata;
	assign wr_ctrl   = bus.wr && a == rtc_pkg::OFS_CONTROL;
	assign wr_flags  = bus.wr && a == rtc_pkg::OFS_FLAGS;
	assign wr_temp   = bus.wr && a == rtc_pkg::OFS_TEMP;
	assign wr_corr   = bus.wr && a == rtc_pkg::OFS_CORRECTION;
	assign wr_src    = bus.wr && a == rtc_pkg::OFS_SOURCE;
	assign wr_cnt_lo = bus.wr && a == rtc_pkg::OFS_COUNT_LO;
	assign wr_cnt_hi = bus.wr && a == rtc_pkg::OFS_COUNT_HI;
	assign wr_lim_lo = bus.wr && a == rtc_pkg::OFS_LIMIT_LO;
	assign wr_lim_hi = bus.wr && a == rtc_pkg::OFS_LIMIT_HI;
	assign wr_mat_lo = bus.wr && a == rtc_pkg::OFS_MATCH_LO;
	assign wr_mat_hi = bus.wr && a == rtc_pkg::OFS_MATCH_HI;
	assign wr_tick   = bus.wr && a == rtc_pkg::OFS_TICK_CTRL;
	assign wr_irqen  = bus.wr && a == rtc_pkg::OFS_TICK_IRQEN;
	assign wr_tflag  = bus.wr && a == rtc_pkg::OFS_TICK_FLAG;
	assign wr_dbg    = bus.wr && a == rtc_pkg::OFS_TICK_DEBUG;
	assign rd_cnt_lo = bus.rd && a == rtc_pkg::OFS_COUNT_LO;
	assign rd_lim_lo = bus.rd && a == rtc_pkg::OFS_LIMIT_LO;
	assign rd_mat_lo = bus.rd && a == rtc_pkg::OFS_MATCH_LO;

	// ----------------------------------------------------------------
	// Plain registers and the shared temporary byte
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_sh_q, ctrl_q, corr_q, tick_sh_q, tick_q;
	logic [7:0]  temp_q, irqen_q, dbg_q;
	logic [15:0] cnt_sh_q, lim_sh_q, cnt_q, lim_q, match_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_sh_q <= rtc_pkg::BYTE_RESET;
			corr_q    <= rtc_pkg::BYTE_RESET;
			source_q  <= rtc_pkg::BYTE_RESET;
			tick_sh_q <= rtc_pkg::BYTE_RESET;
			irqen_q   <= rtc_pkg::BYTE_RESET;
			dbg_q     <= rtc_pkg::BYTE_RESET;
			temp_q    <= rtc_pkg::BYTE_RESET;
			cnt_sh_q  <= rtc_pkg::COUNT_RESET;
			lim_sh_q  <= rtc_pkg::LIMIT_RESET;
			match_q   <= rtc_pkg::MATCH_RESET;
		end else begin
			if (wr_ctrl)  ctrl_sh_q <= wd;
			if (wr_corr)  corr_q    <= wd;
			if (wr_src)   source_q  <= {6'h00, wd[1:0]};
			if (wr_tick)  tick_sh_q <= wd & 8'h79;
			if (wr_irqen) irqen_q   <= {7'h00, wd[0]};
			if (wr_dbg)   dbg_q     <= {7'h00, wd[0]};
			// Low-byte writes park in temp; reads of a low byte fetch high
			if (wr_temp || wr_cnt_lo || wr_lim_lo || wr_mat_lo)
				temp_q <= wd;
			else if (rd_cnt_lo)
				temp_q <= cnt_q[15:8];
			else if (rd_lim_lo)
				temp_q <= lim_sh_q[15:8];
			else if (rd_mat_lo)
				temp_q <= match_q[15:8];
			if (wr_cnt_hi) cnt_sh_q <= {wd, temp_q};
			if (wr_lim_hi) lim_sh_q <= {wd, temp_q};
			if (wr_mat_hi) match_q  <= {wd, temp_q};
		end
	end

	// ----------------------------------------------------------------
	// Synchronisation into the timekeeping ticks
	// ----------------------------------------------------------------
	// A new write restarts its channel; software is expected to wait.
	logic [rtc_pkg::CH_NUM-1:0] sync_start, sync_busy_q, sync_done;
	logic [1:0]                 sync_age_q [rtc_pkg::CH_NUM];
	assign sync_start = {wr_tick, wr_lim_hi, wr_cnt_hi, wr_ctrl};

	genvar gs;
	generate
		for (gs = 0; gs < rtc_pkg::CH_NUM; gs++) begin : g_sync
			assign sync_done[gs] = sync_busy_q[gs] && rtc_tick &&
				sync_age_q[gs] == rtc_pkg::SYNC_LAST;
			always_ff @(posedge clk) begin
				if (srst) begin
					sync_busy_q[gs] <= 1'b0;
					sync_age_q[gs]  <= 2'h0;
				end else if (sync_start[gs]) begin
					sync_busy_q[gs] <= 1'b1;
					sync_age_q[gs]  <= 2'h0;
				end else if (sync_done[gs]) begin
					sync_busy_q[gs] <= 1'b0;
				end else if (sync_busy_q[gs] && rtc_tick) begin
					sync_age_q[gs]  <= sync_age_q[gs] + 2'h1;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Prescaler with correction
	// ----------------------------------------------------------------
	logic        run_en, corr_en, corr_fast;
	logic [3:0]  presc_code;
	logic [15:0] presc_mask;
	logic [14:0] presc_q;
	logic [19:0] acc_q;
	logic [19:0] acc_sum;
	logic        corr_now;
	logic [15:0] presc_add, presc_sum;
	logic        count_step;
	assign run_en     = ctrl_q[rtc_pkg::CTL_ENABLE_BIT];
	assign corr_en    = ctrl_q[rtc_pkg::CTL_CORR_BIT];
	assign corr_fast  = corr_q[rtc_pkg::CORR_SIGN_BIT];
	assign presc_code = ctrl_q[rtc_pkg::CTL_PRESC_LSB +: 4];
	assign presc_mask = pow2_mask({1'b0, presc_code});
	assign acc_sum    = acc_q + {13'h0000, corr_q[6:0]};
	assign corr_now   = rtc_tick && run_en && corr_en &&
		acc_sum >= rtc_pkg::PPM_WINDOW;
	// One source cycle is dropped (slower) or doubled (faster)
	assign presc_add  = !corr_now ? 16'h0001 :
		corr_fast ? 16'h0002 : 16'h0000;
	assign presc_sum  = {1'b0, presc_q} + presc_add;
	assign count_step = rtc_tick && run_en && presc_sum > presc_mask;

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q  <= rtc_pkg::BYTE_RESET;
			presc_q <= 15'h0000;
			acc_q   <= 20'h00000;
		end else begin
			if (sync_done[rtc_pkg::CH_CTRL])
				ctrl_q <= ctrl_sh_q;
			if (rtc_tick && run_en)
				presc_q <= count_step ?
					presc_sum[14:0] - presc_mask[14:0] - 15'h0001 :
					presc_sum[14:0];
			if (!corr_en)
				acc_q <= 20'h00000;
			else if (rtc_tick && run_en)
				acc_q <= corr_now ? acc_sum - rtc_pkg::PPM_WINDOW : acc_sum;
		end
	end

	// ----------------------------------------------------------------
	// Counter, limit and event flags
	// ----------------------------------------------------------------
	logic        wrap_evt, match_evt;
	logic [15:0] cnt_next;
	logic [1:0]  flags_q, flags_d, flags_set;
	assign wrap_evt  = count_step && cnt_q == lim_q;
	assign cnt_next  = wrap_evt ? 16'h0000 : cnt_q + 16'h0001;
	assign match_evt = count_step && cnt_next == match_q;
	assign flags_set = {match_evt, wrap_evt};
	// Set wins over a same-cycle write-one clear
	assign flags_d   = (flags_q & ~(wr_flags ? wd[1:0] : 2'b00)) | flags_set;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q   <= rtc_pkg::COUNT_RESET;
			lim_q   <= rtc_pkg::LIMIT_RESET;
			flags_q <= 2'b00;
		end else begin
			if (sync_done[rtc_pkg::CH_COUNT])
				cnt_q <= cnt_sh_q;
			else if (count_step)
				cnt_q <= cnt_next;
			if (sync_done[rtc_pkg::CH_LIMIT])
				lim_q <= lim_sh_q;
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// Periodic tick timer
	// ----------------------------------------------------------------
	logic        tick_en, tick_halted, tick_run, tick_evt;
	logic [3:0]  tick_code;
	logic [15:0] tick_mask;
	logic [14:0] tick_cnt_q;
	logic        tflag_q, tflag_d;
	assign tick_en     = tick_q[rtc_pkg::TICK_ENABLE_BIT];
	assign tick_code   = tick_q[rtc_pkg::TICK_CODE_LSB +: 4];
	assign tick_halted = debug_halt && !dbg_q[0];
	assign tick_run    = tick_en && tick_code != 4'h0 &&
		tick_code != rtc_pkg::TICK_RESERVED;
	assign tick_mask   = pow2_mask({1'b0, tick_code} + 5'h01);
	assign tick_evt    = rtc_tick && tick_run && !tick_halted &&
		(tick_cnt_q & tick_mask[14:0]) == tick_mask[14:0];
	assign tflag_d     = (tflag_q && !(wr_tflag && wd[0])) || tick_evt;

	always_ff @(posedge clk) begin
		if (srst) begin
			tick_q     <= rtc_pkg::BYTE_RESET;
			tick_cnt_q <= 15'h0000;
			tflag_q    <= 1'b0;
			tick_irq   <= 1'b0;
		end else begin
			if (sync_done[rtc_pkg::CH_TICK])
				tick_q <= tick_sh_q;
			if (!tick_run)
				tick_cnt_q <= 15'h0000;
			else if (rtc_tick && !tick_halted)
				tick_cnt_q <= tick_cnt_q + 15'h0001;
			tflag_q  <= tflag_d;
			tick_irq <= tflag_d && irqen_q[0];
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the read strobe
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	assign rd_mux =
		(a == rtc_pkg::OFS_CONTROL)    ? ctrl_sh_q :
		(a == rtc_pkg::OFS_STATUS)     ? {5'h00, sync_busy_q[2:0]} :
		(a == rtc_pkg::OFS_FLAGS)      ? {6'h00, flags_q} :
		(a == rtc_pkg::OFS_TEMP)       ? temp_q :
		(a == rtc_pkg::OFS_CORRECTION) ? corr_q :
		(a == rtc_pkg::OFS_SOURCE)     ? source_q :
		(a == rtc_pkg::OFS_COUNT_LO)   ? cnt_q[7:0] :
		(a == rtc_pkg::OFS_LIMIT_LO)   ? lim_sh_q[7:0] :
		(a == rtc_pkg::OFS_MATCH_LO)   ? match_q[7:0] :
		(a == rtc_pkg::OFS_COUNT_HI || a == rtc_pkg::OFS_LIMIT_HI ||
		 a == rtc_pkg::OFS_MATCH_HI)   ? temp_q :
		(a == rtc_pkg::OFS_TICK_CTRL)  ? tick_sh_q :
		(a == rtc_pkg::OFS_TICK_STATE) ?
			{7'h00, sync_busy_q[rtc_pkg::CH_TICK]} :
		(a == rtc_pkg::OFS_TICK_IRQEN) ? irqen_q :
		(a == rtc_pkg::OFS_TICK_FLAG)  ? {7'h00, tflag_q} :
		(a == rtc_pkg::OFS_TICK_DEBUG) ? dbg_q : 8'h00;

	always_ff @(posedge clk) begin
		if (srst)
			rd_data <= 8'h00;
		else
			rd_data <= bus.rd ? rd_mux : 8'h00;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_corr_slow_hold: assert property (corr_now && !corr_fast
		|=> presc_q == $past(presc_q))
		else $error("slow correction did not hold prescaler");
	a_corr_spread: assert property (corr_now
		|=> (!corr_now)[*8])
		else $error("corrections bunched together");
	a_corr_window: assert property (corr_now
		|=> acc_q == $past(acc_sum) - rtc_pkg::PPM_WINDOW)
		else $error("correction window not rebased");
	a_tap_rate: assert property (src_sel == rtc_pkg::SRC_KHZ_TAP
		&& rtc_tick |-> pin_rise[0] && tap_cnt_q == rtc_pkg::TAP_LAST)
		else $error("kilohertz tap ticked off rate");
	a_count_apply: assert property (sync_done[rtc_pkg::CH_COUNT]
		|=> cnt_q == $past(cnt_sh_q))
		else $error("count write not applied");
	a_count_two_ticks: assert property ($fell(sync_busy_q[1])
		|-> $past(rtc_tick) && $past(sync_age_q[1]) == 2'h1)
		else $error("count sync not two ticks");
	a_limit_apply: assert property ($fell(sync_busy_q[2])
		|-> lim_q == $past(lim_sh_q) && $past(sync_age_q[2]) == 2'h1)
		else $error("limit write not applied after two ticks");
	a_wrap_event: assert property (wrap_evt && !sync_done[1]
		|=> cnt_q == 16'h0000 && flags_q[rtc_pkg::FLAG_WRAP_BIT])
		else $error("wrap did not clear count or set flag");
	a_match_flag: assert property (match_evt
		|=> flags_q[rtc_pkg::FLAG_MATCH_BIT])
		else $error("match flag not set");
	a_tick_spacing: assert property (tick_evt && tick_code == 4'h1
		|-> tick_cnt_q[1:0] == 2'b11)
		else $error("tick spacing wrong for code 1");
	a_tick_halt: assert property (tick_halted |-> !tick_evt)
		else $error("tick issued while halted in debug");
	a_tick_irq: assert property (tick_evt && irqen_q[0] && !wr_irqen
		|=> tick_irq && tflag_q)
		else $error("tick request not raised");
	a_tick_clear: assert property (wr_tflag && wd[0] && !tick_evt
		|=> !tflag_q && !tick_irq)
		else $error("tick flag not cleared by write one");

	c_wrap: cover property (wrap_evt);
	c_match: cover property (match_evt);
	c_tick_irq: cover property (tick_evt ##1 tick_irq);
	c_correction: cover property (corr_now && corr_fast);

endmodule : rtc_counter

`default_nettype wire

// ==== rtc_crystal_correction_count_tick_timer_tb.sv ====
// Purpose: Self-checking bench for the real-time counter block
// Assumes: Sources stand in fast: edges every 16, 8 and 4 clk
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none

module rtc_crystal_correction_count_tick_timer_tb;

	logic              clk;
	logic              srst;
	rtc_pkg::bus_req_t bus;
	logic [7:0]        rd_data;
	logic              osc_slow_pin;
	logic              crystal_pin;
	logic              ext_clock_pin;
	logic              debug_halt;
	logic              tick_irq;
	logic [2:0]        div_q;
	int                cyc;
	int                num_errors;
	int                checked;

	rtc_counter i_dut (
		.clk           (clk),
		.srst          (srst),
		.bus           (bus),
		.rd_data       (rd_data),
		.osc_slow_pin  (osc_slow_pin),
		.crystal_pin   (crystal_pin),
		.ext_clock_pin (ext_clock_pin),
		.debug_halt    (debug_halt),
		.tick_irq      (tick_irq)
	);

	// ----------------------------------------------------------------
	// Clocks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// A fast stand-in source keeps every tick period short
	always @(posedge clk) begin
		cyc   <= cyc + 1;
		div_q <= div_q + 3'h1;
		if (div_q == 3'h7)
			osc_slow_pin <= ~osc_slow_pin;
		if (div_q[1:0] == 2'h3)
			crystal_pin <= ~crystal_pin;
		if (div_q[0])
			ext_clock_pin <= ~ext_clock_pin;
	end

	// ----------------------------------------------------------------
	// Bus and judging helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic check(input string name, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 data = rd_data;
	endtask : rd

	task automatic poll(input logic [7:0] addr, input logic [7:0] mask,
			input logic [7:0] exp);
		logic [7:0] d;
		for (int i = 0; i < 1000; i++) begin
			rd(addr, d);
			if ((d & mask) === exp) begin
				checked++;
				return;
			end
		end
		num_errors++;
		$display("unexpected poll %h: expected %h, seen %h", addr, exp, d);
		complete_run();
	endtask : poll

	task automatic wait_irq(output int t);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			if (tick_irq === 1'b1) begin
				t = cyc;
				return;
			end
		end
		num_errors++;
		$display("unexpected tick_irq: expected 1, seen 0");
		complete_run();
	endtask : wait_irq

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic reset_values();
		logic [7:0] d;
		logic [7:0] ofs [14] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
			8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h0e};
		for (int i = 0; i < 14; i++) begin
			rd(ofs[i], d);
			check($sformatf("reset %h", ofs[i]), d,
				(i == 4 || i == 5) ? 8'hff : 8'h00);
		end
	endtask : reset_values

	task automatic pair_access();
		logic [7:0] d;
		wr(8'h06, 8'h85);
		rd(8'h06, d);
		check("correction", d, 8'h85);
		wr(8'h07, 8'h03);
		rd(8'h07, d);
		check("source", d, 8'h03);
		wr(8'h07, 8'h00);
		wr(8'h0c, 8'h5a);
		wr(8'h0d, 8'ha5);
		wr(8'h0c, 8'h3c);
		rd(8'h0c, d);
		check("match low held", d, 8'h5a);
		rd(8'h0d, d);
		check("match high", d, 8'ha5);
	endtask : pair_access

	task automatic count_sync();
		logic [7:0] d;
		wr(8'h08, 8'h34);
		wr(8'h09, 8'h12);
		wr(8'h0a, 8'h03);
		wr(8'h0b, 8'h00);
		rd(8'h01, d);
		check("sync busy", d & 8'h06, 8'h06);
		poll(8'h01, 8'h06, 8'h00);
		rd(8'h08, d);
		check("count low", d, 8'h34);
		rd(8'h09, d);
		check("count high", d, 8'h12);
	endtask : count_sync

	task automatic wrap_match();
		logic [7:0] d;
		// Start from zero so the wrap comes after a few steps
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h00);
		poll(8'h01, 8'h02, 8'h00);
		wr(8'h0c, 8'h02);
		wr(8'h0d, 8'h00);
		wr(8'h00, 8'h01);
		poll(8'h03, 8'h03, 8'h03);
		wr(8'h00, 8'h00);
		poll(8'h01, 8'h01, 8'h00);
		wr(8'h03, 8'h01);
		rd(8'h03, d);
		check("flags after clear", d & 8'h03, 8'h02);
	endtask : wrap_match

	task automatic tick_interval(input logic [1:0] sel,
			input logic [3:0] code, input int exp);
		int t0;
		int t1;
		logic [7:0] d;
		wr(8'h07, {6'h00, sel});
		wr(8'h12, 8'h01);
		wr(8'h10, {1'b0, code, 3'h1});
		rd(8'h11, d);
		check("tick ctrl busy", d, 8'h01);
		// Old code may still tick until the new one has landed
		poll(8'h11, 8'h01, 8'h00);
		wr(8'h13, 8'h01);
		wait_irq(t0);
		wr(8'h13, 8'h00);
		rd(8'h13, d);
		check("flag kept", d, 8'h01);
		wr(8'h13, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		check("irq cleared", {7'h0, tick_irq}, 8'h00);
		// The first request may be stale; time two fresh rises instead
		wait_irq(t0);
		wr(8'h13, 8'h01);
		wait_irq(t1);
		check("tick spacing", 8'(t1 - t0), 8'(exp));
		check("spacing high", 8'((t1 - t0) >> 8), 8'(exp >> 8));
		wr(8'h12, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		check("irq masked", {7'h0, tick_irq}, 8'h00);
	endtask : tick_interval

	task automatic no_tick(input logic [7:0] ctrl);
		logic [7:0] d;
		wr(8'h10, ctrl);
		poll(8'h11, 8'h01, 8'h00);
		wr(8'h13, 8'h01);
		repeat (300) @(posedge clk);
		rd(8'h13, d);
		check("quiet tick flag", d, 8'h00);
	endtask : no_tick

	task automatic debug_run();
		wr(8'h15, 8'h00);
		debug_halt <= 1'b1;
		no_tick(8'h09);
		wr(8'h15, 8'h01);
		poll(8'h13, 8'h01, 8'h01);
		debug_halt <= 1'b0;
	endtask : debug_run

	// Long run on the fast pin at divide by two with fast correction;
	// the high byte lands near 0x10 only if the prescaler halves ticks
	task automatic correction_run();
		logic [7:0] d;
		wr(8'h07, 8'h03);
		wr(8'h06, 8'hff);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h00);
		wr(8'h0a, 8'hff);
		wr(8'h0b, 8'hff);
		poll(8'h01, 8'h06, 8'h00);
		wr(8'h00, 8'h0d);
		poll(8'h01, 8'h01, 8'h00);
		repeat (33792) @(posedge clk);
		rd(8'h08, d);
		rd(8'h09, d);
		check("count high after run", d, 8'h10);
		wr(8'h00, 8'h00);
		poll(8'h01, 8'h01, 8'h00);
	endtask : correction_run

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		bus = '0;
		osc_slow_pin = 1'b0;
		crystal_pin = 1'b0;
		ext_clock_pin = 1'b0;
		debug_halt = 1'b0;
		div_q = 3'h0;
		cyc = 0;
		num_errors = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		reset_values();
		pair_access();
		count_sync();
		wrap_match();
		tick_interval(2'h0, 4'h1, 64);
		tick_interval(2'h0, 4'h2, 128);
		tick_interval(2'h1, 4'h1, 2048);
		tick_interval(2'h2, 4'h1, 32);
		tick_interval(2'h3, 4'h1, 16);
		no_tick(8'h01);
		no_tick(8'h79);
		no_tick(8'h08);
		debug_run();
		correction_run();
		complete_run();
	end

endmodule : rtc_crystal_correction_count_tick_timer_tb

`default_nettype wire
